//--- hdl/acx_pkg.sv
// Constants, opcodes and register map of the accumulator execute block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
// Notes on behaviour
// - Add with carry to memory: memory plus working plus carry, all arithmetic flags.
// - Plain add: working plus memory or immediate, no carry in.
// - AND of working with memory or immediate; only zero flag changes.
// - OR of working with memory or immediate; only zero flag changes.
// - Call pushes pc plus one, loads target, two cycles, flags untouched.
// - Clear byte writes zero to memory, flags untouched.
// - Clear bit zeroes only the selected bit, flags untouched.
// - Watchdog clear resets counter and clears power-down flag; clears expiry flag unless the watchdog expires that cycle.
// - Invert memory in place and update zero flag.
// - Invert to working leaves memory alone, updates zero flag.
// - Decimal adjust adds 6 to low nibble above 9 or half-carry; result to memory.
// - Decimal adjust adds 6 to high nibble above 9 or carry; only carry changes.
// - Decrement memory in place or into working; only zero flag changes.
// - Increment memory in place or into working; only zero flag changes.
// - Halt stops execution, clears watchdog, sets power-down, clears expiry unless the watchdog expires that cycle.
// - Goto loads target and inserts one dummy cycle, flags untouched.
// - Move memory or immediate into working, flags untouched.
// - Store copies working into memory, flags untouched.
// - Return pops pc; immediate variant also loads working; flags untouched.
// - Interrupt return pops pc, sets global enable, pending interrupt served first.
// - Rotate left with bit 7 into bit 0, to memory or working.
// - Rotate through carry: old carry to bit 0, old bit 7 to carry.
// - Any write of the pc low byte takes two cycles.
package acx_pkg;
  localparam int PC_W      = 10;
  localparam int MEM_DEPTH = 16;
  localparam int STK_DEPTH = 8;

  localparam logic [7:0] ADDR_INSN = 8'h00;
  localparam logic [7:0] ADDR_WORK = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_PC   = 8'h0c;
  localparam logic [7:0] ADDR_WDOG = 8'h10;
  localparam logic [7:0] ADDR_MEM  = 8'h40;
  localparam logic [7:0] ADDR_MEM_END = 8'h7c;

  // Instruction word fields
  localparam int F_OP_LO  = 0;
  localparam int F_BIT_LO = 6;
  localparam int F_ADR_LO = 9;
  localparam int F_IMM_LO = 13;
  localparam int F_TGT_LO = 21;

  // Status word fields
  localparam int S_C    = 0;
  localparam int S_HC   = 1;
  localparam int S_Z    = 2;
  localparam int S_WRAP = 3;
  localparam int S_SCMP = 4;
  localparam int S_TO   = 5;
  localparam int S_PDN  = 6;
  localparam int S_GIE  = 7;
  localparam int S_BUSY = 8;
  localparam int S_HALT = 9;
  localparam int S_WAKE = 10;

  localparam logic [3:0]      PC_LO_IDX  = 4'hf;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h004;
  localparam logic [PC_W-1:0] PC_RESET   = 10'h000;
  localparam logic [3:0]      BCD_MAX    = 4'h9;
  localparam logic [3:0]      BCD_FIX    = 4'h6;
  localparam logic [7:0]      WDOG_MAX   = 8'hff;
  localparam logic [7:0]      PRE_MAX    = 8'hff;

  typedef enum logic [5:0] {
    OP_IDLE, OP_ADD_M, OP_ADD_X, OP_ADD_TO_MEM, OP_ADC_TO_MEM,
    OP_AND_M, OP_AND_X, OP_AND_TO_MEM, OP_OR_M, OP_OR_X, OP_OR_TO_MEM,
    OP_CALL, OP_CLR, OP_CLR_BIT, OP_CLR_WDOG, OP_INV_MEM, OP_INV_WORK,
    OP_DEC_ADJ, OP_DEC, OP_DEC_WORK, OP_INC, OP_INC_WORK, OP_HALT, OP_GOTO,
    OP_MOV_M, OP_MOV_X, OP_STORE, OP_RET, OP_RET_X, OP_IRQ_RET,
    OP_RL, OP_RL_WORK, OP_RL_CARRY
  } acx_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} acx_state_t;
endpackage

//--- hdl/acx_exec_core.sv
// Accumulator execute unit with flip-flop data memory, stack and watchdog.
// Assumes a classic Wishbone master on core_clk and an asynchronous irqReq pin.
`timescale 1ns/1ps
module acx_exec_core (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        irqReq,
  output logic             sysClkOff
);
  import acx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]           mem_q [MEM_DEPTH];
  logic [PC_W-1:0]      stack_q [STK_DEPTH];
  logic [2:0]           sp_q;
  logic [PC_W-1:0]      pc_q;
  logic [7:0]           work_q;
  logic                 c_q, hc_q, z_q, wrap_q, scmp_q, gie_q;
  logic                 to_q, pdn_q, halted_q;
  logic [7:0]           wdog_q, pre_q;
  acx_state_t           state_q;
  acx_op_t              op_q;
  logic [2:0]           bit_q;
  logic [3:0]           adr_q;
  logic [7:0]           imm_q;
  logic [PC_W-1:0]      tgt_q;
  logic                 irqMeta_q, irqSync_q;

  logic                 busReq, busWr, idle, accept, exec, wdogExpire, wakeWr;
  logic [3:0]           busIdx;
  logic [7:0]           mval, addB, logicB, res, corr;
  logic                 addCin, wrMem, wrAcc, updZ, updArith, updC, newC;
  logic                 twoCyc, loAdj, hiAdj, pcLoWr;
  logic [10:0]          addRes;
  logic [31:0]          rdData;

  function automatic logic [7:0] memRead(input logic [3:0] idx);
    memRead = (idx == PC_LO_IDX) ? pc_q[7:0] : mem_q[idx];
  endfunction

  // True for a word-aligned address inside the data memory window
  function automatic logic memHit(input logic [7:0] a);
    memHit = a >= ADDR_MEM && a <= ADDR_MEM_END && a[1:0] == 2'b00;
  endfunction

  // Returns {ov, ac, c, sum}
  function automatic logic [10:0] acxAdd(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [4:0] lo;
    logic [7:0] low7;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    acxAdd = {low7[7] ^ full[8], lo[4], full[8], full[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, writes land at the ack edge
  assign busReq = wb_cyc_i & wb_stb_i;
  assign busWr  = busReq & wb_we_i & wb_ack_o;
  assign busIdx = wb_adr_i[5:2];
  assign idle   = (state_q == ST_IDLE);
  assign accept = busWr && wb_adr_i == ADDR_INSN && wb_sel_i == 4'hf && idle && !halted_q;
  assign exec   = (state_q == ST_EXEC);
  assign wakeWr = busWr && wb_adr_i == ADDR_STAT && wb_sel_i[1] && wb_dat_i[S_WAKE];

  always_comb begin
    rdData = 32'h0000_0000;
    if (wb_adr_i == ADDR_WORK) begin
      rdData[7:0] = work_q;
    end else if (wb_adr_i == ADDR_STAT) begin
      rdData[S_HALT:0] = {halted_q, !idle, gie_q, pdn_q, to_q, scmp_q, wrap_q, z_q, hc_q, c_q};
    end else if (wb_adr_i == ADDR_PC) begin
      rdData[PC_W-1:0] = pc_q;
      rdData[18:16]    = sp_q;
    end else if (wb_adr_i == ADDR_WDOG) begin
      rdData[15:0] = {wdog_q, pre_q};
    end else if (memHit(wb_adr_i)) begin
      rdData[7:0] = memRead(busIdx);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq & !wb_ack_o;
      if (busReq && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rdData;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMeta_q <= 1'b0;
      irqSync_q <= 1'b0;
    end else begin
      irqMeta_q <= irqReq;
      irqSync_q <= irqMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q    <= OP_IDLE;
      bit_q   <= 3'h0;
      adr_q   <= 4'h0;
      imm_q   <= 8'h00;
      tgt_q   <= PC_RESET;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_EXEC;
            op_q    <= acx_op_t'(wb_dat_i[F_OP_LO +: 6]);
            bit_q   <= wb_dat_i[F_BIT_LO +: 3];
            adr_q   <= wb_dat_i[F_ADR_LO +: 4];
            imm_q   <= wb_dat_i[F_IMM_LO +: 8];
            tgt_q   <= wb_dat_i[F_TGT_LO +: PC_W];
          end
        end
        ST_EXEC:  state_q <= twoCyc ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  assign mval   = memRead(adr_q);
  assign addB   = (op_q == OP_ADD_X) ? imm_q : mval;
  assign addCin = (op_q == OP_ADC_TO_MEM) & c_q;
  assign addRes = acxAdd(work_q, addB, addCin);
  assign logicB = (op_q == OP_AND_X || op_q == OP_OR_X) ? imm_q : mval;
  assign loAdj  = (work_q[3:0] > BCD_MAX) | hc_q;
  assign hiAdj  = (work_q[7:4] > BCD_MAX) | c_q;
  assign corr   = {hiAdj ? BCD_FIX : 4'h0, loAdj ? BCD_FIX : 4'h0};

  always_comb begin
    res      = 8'h00;
    wrMem    = 1'b0;
    wrAcc    = 1'b0;
    updZ     = 1'b0;
    updArith = 1'b0;
    updC     = 1'b0;
    newC     = c_q;
    unique case (op_q)
      OP_ADD_M, OP_ADD_X: begin
        res = addRes[7:0]; wrAcc = 1'b1; updArith = 1'b1;
      end
      OP_ADD_TO_MEM, OP_ADC_TO_MEM: begin
        res = addRes[7:0]; wrMem = 1'b1; updArith = 1'b1;
      end
      OP_AND_M, OP_AND_X:   begin res = work_q & logicB; wrAcc = 1'b1; updZ = 1'b1; end
      OP_AND_TO_MEM:        begin res = work_q & mval;   wrMem = 1'b1; updZ = 1'b1; end
      OP_OR_M, OP_OR_X:     begin res = work_q | logicB; wrAcc = 1'b1; updZ = 1'b1; end
      OP_OR_TO_MEM:         begin res = work_q | mval;   wrMem = 1'b1; updZ = 1'b1; end
      OP_CLR:               begin res = 8'h00; wrMem = 1'b1; end
      OP_CLR_BIT: begin
        res = mval & ~(8'h01 << bit_q); wrMem = 1'b1;
      end
      OP_INV_MEM:           begin res = ~mval; wrMem = 1'b1; updZ = 1'b1; end
      OP_INV_WORK:          begin res = ~mval; wrAcc = 1'b1; updZ = 1'b1; end
      OP_DEC_ADJ: begin
        res = work_q + corr; wrMem = 1'b1; updC = 1'b1; newC = hiAdj;
      end
      OP_DEC:               begin res = mval - 8'h01; wrMem = 1'b1; updZ = 1'b1; end
      OP_DEC_WORK:          begin res = mval - 8'h01; wrAcc = 1'b1; updZ = 1'b1; end
      OP_INC:               begin res = mval + 8'h01; wrMem = 1'b1; updZ = 1'b1; end
      OP_INC_WORK:          begin res = mval + 8'h01; wrAcc = 1'b1; updZ = 1'b1; end
      OP_MOV_M:             begin res = mval;   wrAcc = 1'b1; end
      OP_MOV_X, OP_RET_X:   begin res = imm_q;  wrAcc = 1'b1; end
      OP_STORE:             begin res = work_q; wrMem = 1'b1; end
      OP_RL:                begin res = {mval[6:0], mval[7]}; wrMem = 1'b1; end
      OP_RL_WORK:           begin res = {mval[6:0], mval[7]}; wrAcc = 1'b1; end
      OP_RL_CARRY: begin
        res = {mval[6:0], c_q}; wrMem = 1'b1; updC = 1'b1; newC = mval[7];
      end
      default: ;
    endcase
  end

  assign pcLoWr = wrMem && adr_q == PC_LO_IDX;
  assign twoCyc = pcLoWr || op_q == OP_CALL || op_q == OP_GOTO
                  || op_q == OP_RET || op_q == OP_RET_X || op_q == OP_IRQ_RET;

  ////////////////////////////////////////////////////////////////////////////
  // Working register and data memory; bus writes only while idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      work_q <= 8'h00;
    end else if (exec && wrAcc) begin
      work_q <= res;
    end else if (idle && busWr && wb_adr_i == ADDR_WORK && wb_sel_i[0]) begin
      work_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (exec && wrMem && !pcLoWr) begin
      mem_q[adr_q] <= res;
    end else if (idle && busWr && wb_sel_i[0] && busIdx != PC_LO_IDX && memHit(wb_adr_i)) begin
      mem_q[busIdx] <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and stack
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_q <= PC_RESET;
      sp_q <= 3'h0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stack_q[i] <= PC_RESET;
      end
    end else if (exec) begin
      unique case (op_q)
        OP_CALL: begin
          stack_q[sp_q] <= pc_q + 10'h001;
          sp_q          <= sp_q + 3'h1;
          pc_q          <= tgt_q;
        end
        OP_GOTO: pc_q <= tgt_q;
        OP_RET, OP_RET_X, OP_IRQ_RET: begin
          sp_q <= sp_q - 3'h1;
          pc_q <= stack_q[sp_q - 3'h1];
        end
        default: begin
          if (pcLoWr) begin
            pc_q[7:0] <= res;
          end else begin
            pc_q <= pc_q + 10'h001;
          end
        end
      endcase
    end else if (state_q == ST_DUMMY && op_q == OP_IRQ_RET && irqSync_q) begin
      // Pending request is taken before the main program resumes
      stack_q[sp_q] <= pc_q;
      sp_q          <= sp_q + 3'h1;
      pc_q          <= IRQ_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic flags and global interrupt enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {c_q, hc_q, z_q, wrap_q, scmp_q, gie_q} <= 6'h00;
    end else if (exec) begin
      if (updArith) begin
        c_q    <= addRes[8];
        hc_q   <= addRes[9];
        wrap_q <= addRes[10];
        scmp_q <= addRes[10] ^ addRes[7];
      end
      if (updArith || updZ) begin
        z_q <= (res == 8'h00);
      end
      if (updC) begin
        c_q <= newC;
      end
      if (op_q == OP_IRQ_RET) begin
        gie_q <= 1'b1;
      end
    end else if (state_q == ST_DUMMY && op_q == OP_IRQ_RET && irqSync_q) begin
      gie_q <= 1'b0;
    end else if (idle && busWr && wb_adr_i == ADDR_STAT && wb_sel_i[0]) begin
      {c_q, hc_q, z_q, wrap_q, scmp_q} <= {wb_dat_i[S_C], wb_dat_i[S_HC], wb_dat_i[S_Z],
                                           wb_dat_i[S_WRAP], wb_dat_i[S_SCMP]};
      gie_q <= wb_dat_i[S_GIE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and power-down; the watchdog keeps counting while halted so it can wake
  assign wdogExpire = (wdog_q == WDOG_MAX) && (pre_q == PRE_MAX);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdog_q <= 8'h00;
      pre_q  <= 8'h00;
    end else if (exec && (op_q == OP_CLR_WDOG || op_q == OP_HALT)) begin
      wdog_q <= 8'h00;
      pre_q  <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
      if (pre_q == PRE_MAX) begin
        wdog_q <= wdog_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      to_q  <= 1'b0;
      pdn_q <= 1'b0;
    end else begin
      if (wdogExpire) begin
        to_q <= 1'b1;
      end else if (exec && (op_q == OP_CLR_WDOG || op_q == OP_HALT)) begin
        to_q <= 1'b0;
      end
      if (exec && op_q == OP_CLR_WDOG) begin
        pdn_q <= 1'b0;
      end else if (exec && op_q == OP_HALT) begin
        pdn_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      halted_q  <= 1'b0;
      sysClkOff <= 1'b0;
    end else if (exec && op_q == OP_HALT) begin
      halted_q  <= 1'b1;
      sysClkOff <= 1'b1;
    end else if (wakeWr || wdogExpire) begin
      halted_q  <= 1'b0;
      sysClkOff <= 1'b0;
    end
  end

endmodule // acx_exec_core

//--- test/acx_irq_model.sv
// Far-side model: the interrupt source that raises the pending level.
// Assumes the bench commands it; the level is held until withdrawn.
`timescale 1ns/1ps
module acx_irq_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pendCmd,
  output logic      irqReq
);
  // A real source holds its request as a level until serviced
  always_ff @(posedge core_clk) begin
    irqReq <= rst ? 1'b0 : pendCmd;
  end
endmodule // acx_irq_model

//--- test/acx_exec_props.sv
// Bus-side assertions for the execute unit.
// Assumes it is bound to acx_exec_core and sees only its ports.
`timescale 1ns/1ps
module acx_exec_props
  import acx_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irqReq,
  input wire logic        sysClkOff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic rdAck;
  assign rdAck = wb_ack_o && !wb_we_i;
  ////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one wait cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_reset_quiet: assert property ($past(rst) |-> !wb_ack_o && wb_dat_o == 32'h0 && !sysClkOff)
    else $error("outputs not cleared by reset");
  a_mem_byte: assert property (rdAck && wb_adr_i >= ADDR_MEM |-> wb_dat_o[31:8] == 24'h0)
    else $error("memory read has upper bits set");
  a_unmapped_zero: assert property (rdAck && wb_adr_i inside {[8'h14:8'h3c]} |->
                                    wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_pc_fields: assert property (rdAck && wb_adr_i == ADDR_PC |->
                                wb_dat_o[31:19] == 13'h0 && wb_dat_o[15:10] == 6'h0)
    else $error("pc read has stray bits");
  a_work_byte: assert property (rdAck && wb_adr_i == ADDR_WORK |-> wb_dat_o[31:8] == 24'h0)
    else $error("working read has upper bits set");
  a_stat_width: assert property (rdAck && wb_adr_i == ADDR_STAT |-> wb_dat_o[31:11] == 21'h0)
    else $error("status read has stray bits");
endmodule // acx_exec_props

bind acx_exec_core acx_exec_props i_props (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irqReq(irqReq),
  .sysClkOff(sysClkOff));

//--- test/tb_accumulator_instruction_execute.sv
// Self-checking bench: instructions issued and results read over Wishbone.
// Assumes the register map and one-wait-cycle answer of the execute unit.
`timescale 1ns/1ps
module tb_accumulator_instruction_execute;
  import acx_pkg::*;
  logic        core_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pend = 0, irqReq, sysClkOff;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic        ack;
  logic [9:0]  p;
  logic [2:0]  sp;
  int          errTotal = 0, nChecks = 0;
  logic [7:0]  dW[3] = '{8'h7b, 8'ha2, 8'h10}, dS[3] = '{8'h00, 8'h00, 8'h02};
  logic [7:0]  dM[3] = '{8'h81, 8'h02, 8'h16}, dF[3] = '{8'h00, 8'h01, 8'h02};
  always #5 core_clk = ~core_clk;
  acx_exec_core i_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irqReq(irqReq), .sysClkOff(sysClkOff));
  acx_irq_model i_irq (.core_clk(core_clk), .rst(rst), .pendCmd(pend), .irqReq(irqReq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wbx(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    // Only the watchdog process ends a wait that never sees ack
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); wbx(a, 1'b1, d); endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    wbx(a, 1'b0, 32'h0);
    chk(q & m, exp);
  endtask
  function automatic logic [7:0] mA(input int i); return ADDR_MEM + 8'(4 * i); endfunction
  // Busy must clear before the next instruction, else the write is dropped
  task automatic ex(input logic [5:0] op, input logic [2:0] b, input logic [3:0] i,
                    input logic [7:0] imm, input logic [9:0] t);
    int n;
    wr(ADDR_INSN, {1'b0, t, imm, i, b, op});
    n = 0;
    do begin wbx(ADDR_STAT, 1'b0, 32'h0); n++; end while (q[S_BUSY] !== 1'b0 && n < 20);
    if (q[S_BUSY] !== 1'b0) errTotal++;
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 0;
    rchk(ADDR_PC, 32'h703ff, 32'h0);
    wr(mA(1), 32'h3c); wr(ADDR_WORK, 32'h5a); wr(ADDR_STAT, 32'h0);
    ex(OP_ADD_M, 0, 1, 0, 0);
    rchk(ADDR_WORK, 32'hff, 32'h96); rchk(ADDR_STAT, 32'hff, 32'h0a);
    ex(OP_ADD_X, 0, 0, 8'h6a, 0);
    rchk(ADDR_WORK, 32'hff, 32'h00); rchk(ADDR_STAT, 32'hff, 32'h07);
    wr(ADDR_WORK, 32'hff); wr(mA(2), 32'h01);
    ex(OP_ADC_TO_MEM, 0, 2, 0, 0);
    rchk(mA(2), 32'hff, 32'h01); rchk(ADDR_STAT, 32'hff, 32'h03);
    ex(OP_ADD_TO_MEM, 0, 2, 0, 0);
    rchk(mA(2), 32'hff, 32'h00); rchk(ADDR_STAT, 32'hff, 32'h07);
    wr(ADDR_WORK, 32'hf0); ex(OP_AND_X, 0, 0, 8'h0f, 0);
    rchk(ADDR_WORK, 32'hff, 32'h0); rchk(ADDR_STAT, 32'hff, 32'h07);
    wr(ADDR_WORK, 32'h0f); wr(mA(3), 32'ha0); ex(OP_OR_TO_MEM, 0, 3, 0, 0);
    rchk(mA(3), 32'hff, 32'haf); rchk(ADDR_STAT, 32'hff, 32'h03);
    ex(OP_OR_X, 0, 0, 8'hf0, 0); rchk(ADDR_WORK, 32'hff, 32'hff);
    ex(OP_AND_M, 0, 3, 0, 0); rchk(ADDR_WORK, 32'hff, 32'haf);
    ex(OP_AND_TO_MEM, 0, 1, 0, 0); rchk(mA(1), 32'hff, 32'h2c);
    wr(ADDR_WORK, 32'h50); ex(OP_OR_M, 0, 1, 0, 0);
    rchk(ADDR_WORK, 32'hff, 32'h7c); rchk(ADDR_STAT, 32'hff, 32'h03);
    ex(OP_CLR, 0, 3, 0, 0);
    rchk(mA(3), 32'hff, 32'h0); rchk(ADDR_STAT, 32'hff, 32'h03);
    wr(mA(3), 32'hff); ex(OP_CLR_BIT, 3'd7, 3, 0, 0); rchk(mA(3), 32'hff, 32'h7f);
    ex(OP_INV_MEM, 0, 3, 0, 0); rchk(mA(3), 32'hff, 32'h80);
    ex(OP_INV_WORK, 0, 3, 0, 0);
    rchk(ADDR_WORK, 32'hff, 32'h7f); rchk(mA(3), 32'hff, 32'h80);
    wr(mA(4), 32'h01); ex(OP_DEC, 0, 4, 0, 0);
    rchk(mA(4), 32'hff, 32'h0); rchk(ADDR_STAT, 32'hff, 32'h07);
    ex(OP_DEC_WORK, 0, 4, 0, 0); rchk(ADDR_WORK, 32'hff, 32'hff);
    ex(OP_INC_WORK, 0, 4, 0, 0);
    rchk(ADDR_WORK, 32'hff, 32'h01); rchk(mA(4), 32'hff, 32'h0);
    ex(OP_INC, 0, 4, 0, 0); rchk(mA(4), 32'hff, 32'h01); rchk(ADDR_STAT, 32'h04, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_WORK, {24'h0, dW[k]}); wr(ADDR_STAT, {24'h0, dS[k]});
      ex(OP_DEC_ADJ, 0, 5, 0, 0);
      rchk(mA(5), 32'hff, {24'h0, dM[k]});
      rchk(ADDR_STAT, 32'hff, {24'h0, dF[k]});
    end
    wr(mA(6), 32'h81); ex(OP_RL, 0, 6, 0, 0); rchk(mA(6), 32'hff, 32'h03);
    ex(OP_RL_WORK, 0, 6, 0, 0);
    rchk(ADDR_WORK, 32'hff, 32'h06); rchk(mA(6), 32'hff, 32'h03);
    wr(mA(6), 32'h81); wr(ADDR_STAT, 32'h0); ex(OP_RL_CARRY, 0, 6, 0, 0);
    rchk(mA(6), 32'hff, 32'h02); rchk(ADDR_STAT, 32'hff, 32'h01);
    ex(OP_RL_CARRY, 0, 6, 0, 0);
    rchk(mA(6), 32'hff, 32'h05); rchk(ADDR_STAT, 32'hff, 32'h00);
    ex(OP_MOV_M, 0, 6, 0, 0); rchk(ADDR_WORK, 32'hff, 32'h05);
    ex(OP_MOV_X, 0, 0, 8'h3c, 0); ex(OP_STORE, 0, 7, 0, 0);
    rchk(mA(7), 32'hff, 32'h3c); rchk(ADDR_STAT, 32'hff, 32'h0);
    wbx(ADDR_PC, 1'b0, 32'h0); p = q[9:0]; sp = q[18:16];
    ex(OP_CALL, 0, 0, 0, 10'h123);
    rchk(ADDR_PC, 32'h703ff, {13'h0, sp + 3'h1, 6'h0, 10'h123});
    ex(OP_RET_X, 0, 0, 8'h55, 0);
    rchk(ADDR_PC, 32'h703ff, {13'h0, sp, 6'h0, p + 10'h1});
    rchk(ADDR_WORK, 32'hff, 32'h55); rchk(ADDR_STAT, 32'hff, 32'h0);
    ex(OP_CALL, 0, 0, 0, 10'h155); ex(OP_RET, 0, 0, 0, 0);
    rchk(ADDR_PC, 32'h3ff, {22'h0, p + 10'h2});
    ex(OP_GOTO, 0, 0, 0, 10'h200); rchk(ADDR_PC, 32'h3ff, 32'h200);
    ex(OP_IDLE, 0, 0, 0, 0); rchk(ADDR_PC, 32'h3ff, 32'h201);
    rchk(ADDR_WORK, 32'hff, 32'h55); rchk(ADDR_STAT, 32'hff, 32'h0);
    ex(OP_CALL, 0, 0, 0, 10'h0f0); ex(OP_IRQ_RET, 0, 0, 0, 0);
    rchk(ADDR_PC, 32'h3ff, 32'h202); rchk(ADDR_STAT, 32'hff, 32'h80);
    ex(OP_CALL, 0, 0, 0, 10'h0f0);
    pend <= 1; // A pending request must be served before the return lands
    repeat (5) @(posedge core_clk);
    ex(OP_IRQ_RET, 0, 0, 0, 0);
    rchk(ADDR_PC, 32'h3ff, {22'h0, IRQ_VECTOR}); rchk(ADDR_STAT, 32'h80, 32'h0);
    pend <= 0;
    wr(ADDR_WORK, 32'h40); ex(OP_STORE, 0, PC_LO_IDX, 0, 0);
    rchk(ADDR_PC, 32'h3ff, 32'h040); rchk(ADDR_MEM_END, 32'hff, 32'h40);
    wr(ADDR_MEM_END, 32'h77); rchk(ADDR_PC, 32'h3ff, 32'h040);
    // Let the watchdog counter move so that each clear is visible
    repeat (300) @(posedge core_clk);
    ex(OP_HALT, 0, 0, 0, 0);
    chk({31'h0, sysClkOff}, 32'h1);
    rchk(ADDR_STAT, 32'h260, 32'h240); rchk(ADDR_WDOG, 32'hff00, 32'h0);
    wr(ADDR_STAT, 32'h400);
    // The wake lands at the ack edge, so look one edge later
    @(posedge core_clk);
    chk({31'h0, sysClkOff}, 32'h0);
    repeat (300) @(posedge core_clk);
    ex(OP_CLR_WDOG, 0, 0, 0, 0);
    rchk(ADDR_STAT, 32'h260, 32'h0); rchk(ADDR_WDOG, 32'hff00, 32'h0);
    rchk(8'h20, 32'hffffffff, 32'h0);
    summarize;
  end
endmodule // tb_accumulator_instruction_execute
